// File: rtl/sarpr_pkg.sv
// Shared constants, types and helpers of the converter control and readout block
package sarpr_pkg;

    // Result and conversion sequence
    localparam int          RES_W        = 16;
    localparam int          BYTE_W       = 8;
    localparam int          EDGE_W       = 5;
    localparam logic [4:0]  CONV_EDGES   = 5'h10;
    localparam logic [4:0]  LATCH_EDGE   = 5'h11;
    localparam logic [15:0] TRIAL_START  = 16'h8000;
    localparam logic [15:0] RESULT_RST   = 16'h0000;
    localparam logic [15:0] COUNT_RST    = 16'h0000;

    // Register bus
    localparam int          AVS_AW       = 4;
    localparam int          AVS_DW       = 32;
    localparam logic [3:0]  OFF_CTRL     = 4'h0;
    localparam logic [3:0]  OFF_STATUS   = 4'h4;
    localparam logic [3:0]  OFF_RESULT   = 4'h8;
    localparam logic [3:0]  OFF_COUNT    = 4'hc;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_GO_BIT  = 1;
    localparam logic        CTRL_EN_RST  = 1'b1;
    localparam int          STAT_BUSY    = 0;
    localparam int          STAT_HOLD    = 1;
    localparam int          STAT_EDGE_LO = 8;

    typedef enum logic [1:0] {
        ST_ACQ  = 2'b01,
        ST_CONV = 2'b10
    } sarpr_state_t;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [AVS_AW-1:0] address;
        logic [AVS_DW-1:0] writedata;
    } sarpr_avs_req_t;

    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic byte_sel;
    } sarpr_rdctl_t;

    // Full result or its upper byte, placed on the bus for a given byte select
    function automatic logic [15:0] sarpr_present(input logic [15:0] res, input logic byte_sel);
        sarpr_present = byte_sel ? {8'h00, res[15:8]} : res;
    endfunction : sarpr_present

endpackage : sarpr_pkg

// File: rtl/sarpr_read_port.sv
// Three-state parallel result bus driver with byte select
`timescale 1ns/100ps
module sarpr_read_port (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Host strobes and result
    input  wire sarpr_pkg::sarpr_rdctl_t rdctl,
    input  wire logic [15:0]           result,
    // Bus pins
    output logic [15:0]                result_bus_out,
    output logic [15:0]                result_bus_oe_n
);
    logic [15:0] bus_ff;
    logic [15:0] nxt_bus;

    // Follows byte select every cycle, so the bus settles one cycle after a change
    always_comb begin
        nxt_bus = sarpr_pkg::sarpr_present(result, rdctl.byte_sel);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_ff <= sarpr_pkg::RESULT_RST;
        end else begin
            bus_ff <= nxt_bus;
        end
    end

    assign result_bus_out  = bus_ff;
    assign result_bus_oe_n = {16{rdctl.cs_n | rdctl.rd_n}};

endmodule : sarpr_read_port

// File: rtl/sarpr_avs_regs.sv
// Avalon-MM register slave: control, status, result and conversion count
`timescale 1ns/100ps
module sarpr_avs_regs (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Bus request and answer
    input  wire sarpr_pkg::sarpr_avs_req_t req,
    output logic [31:0]                readdata,
    output logic                       waitrequest,
    // Control to the sequencer
    output logic                       start_en,
    output logic                       sw_start,
    // State from the sequencer
    input  wire logic                  busy,
    input  wire logic                  hold,
    input  wire logic [4:0]            edge_cnt,
    input  wire logic [15:0]           result,
    input  wire logic [15:0]           conv_count
);
    logic        ack_ff;
    logic        en_ff;
    logic        go_ff;
    logic [31:0] rdata_ff;
    logic        nxt_ack;
    logic        nxt_en;
    logic        nxt_go;
    logic [31:0] nxt_rdata;
    logic        req_any;

    // One wait cycle per access keeps the read mux out of the bus path
    always_comb begin
        req_any   = req.read | req.write;
        nxt_ack   = req_any & ~ack_ff;
        nxt_en    = en_ff;
        nxt_go    = 1'b0;
        nxt_rdata = rdata_ff;
        if (nxt_ack && req.write && req.address == sarpr_pkg::OFF_CTRL) begin
            nxt_en = req.writedata[sarpr_pkg::CTRL_EN_BIT];
            nxt_go = req.writedata[sarpr_pkg::CTRL_GO_BIT];
        end
        if (nxt_ack && req.read) begin
            case (req.address)
                sarpr_pkg::OFF_CTRL: begin
                    nxt_rdata = {31'h0, en_ff};
                end
                sarpr_pkg::OFF_STATUS: begin
                    nxt_rdata = 32'h0;
                    nxt_rdata[sarpr_pkg::STAT_BUSY] = busy;
                    nxt_rdata[sarpr_pkg::STAT_HOLD] = hold;
                    nxt_rdata[sarpr_pkg::STAT_EDGE_LO +: sarpr_pkg::EDGE_W] = edge_cnt;
                end
                sarpr_pkg::OFF_RESULT: begin
                    nxt_rdata = {16'h0, result};
                end
                sarpr_pkg::OFF_COUNT: begin
                    nxt_rdata = {16'h0, conv_count};
                end
                default: begin
                    nxt_rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_ff   <= 1'b0;
            en_ff    <= sarpr_pkg::CTRL_EN_RST;
            go_ff    <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff   <= nxt_ack;
            en_ff    <= nxt_en;
            go_ff    <= nxt_go;
            rdata_ff <= nxt_rdata;
        end
    end

    assign waitrequest = req_any & ~ack_ff;
    assign readdata    = rdata_ff;
    assign start_en    = en_ff;
    assign sw_start    = go_ff;

endmodule : sarpr_avs_regs

// File: rtl/sarpr_top.sv
// Successive-approximation conversion control with parallel result readout
`timescale 1ns/100ps
// What this block does
// - Start falling edge with select low moves input to hold
// - First clock rise starts; sixteen rises convert
// - Busy rises promptly, stays high during conversion
// - Busy low initially; reads never change it
// - Seventeenth rise latches result, busy drops
// - Bus undriven unless read and select low
// - Data valid after 40 ns joint low
// - Byte select low gives full word
// - Byte select high moves upper byte low
// - Further start pulses ignored until done
// - After conversion, resume sampling input
// - Result coded as two's complement
// - Byte select sampled on sys_clk, bus follows it one cycle later
module sarpr_top (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    rst,
    // Conversion control pins
    input  wire logic                    conv_clk,
    input  wire logic                    conversion_start_n,
    output logic                         busy,
    // Analog interface of the capacitive weighting array
    input  wire logic                    cmp_above,
    output logic [15:0]                  capacitive_weighting_array,
    output logic                         sample_hold,
    // Parallel readout pins
    input  wire sarpr_pkg::sarpr_rdctl_t rdctl,
    output logic [15:0]                  result_bus_out,
    output logic [15:0]                  result_bus_oe_n,
    // Avalon-MM register slave
    input  wire logic [3:0]              avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [31:0]             avs_writedata,
    output logic [31:0]                  avs_readdata,
    output logic                         avs_waitrequest
);
    sarpr_pkg::sarpr_state_t   state_ff;
    sarpr_pkg::sarpr_state_t   nxt_state;
    sarpr_pkg::sarpr_avs_req_t avs_req;

    logic        start_prev_ff;
    logic        clk_prev_ff;
    logic        busy_ff;
    logic        hold_ff;
    logic [4:0]  edge_ff;
    logic [15:0] trial_ff;
    logic [15:0] result_ff;
    logic [15:0] count_ff;

    logic        nxt_busy;
    logic        nxt_hold;
    logic [4:0]  nxt_edge;
    logic [15:0] nxt_trial;
    logic [15:0] nxt_result;
    logic [15:0] nxt_count;

    logic        start_fall;
    logic        clk_rise;
    logic        trigger;
    logic        start_en;
    logic        sw_start;
    logic [4:0]  edge_inc;
    logic [3:0]  bit_idx;

    assign avs_req.read      = avs_read;
    assign avs_req.write     = avs_write;
    assign avs_req.address   = avs_address;
    assign avs_req.writedata = avs_writedata;

    // Pins are synchronous to sys_clk, so edges are found from one stored sample
    always_comb begin
        start_fall = start_prev_ff & ~conversion_start_n;
        clk_rise   = conv_clk & ~clk_prev_ff;
        // Select must be low when start falls; a held-low start makes no new fall
        trigger    = ((start_fall & ~rdctl.cs_n) | sw_start) & start_en;
        edge_inc   = edge_ff + 5'h01;
        bit_idx    = 4'(sarpr_pkg::CONV_EDGES - edge_inc);
    end

    // Conversion sequencer
    always_comb begin
        nxt_state  = state_ff;
        nxt_busy   = busy_ff;
        nxt_hold   = hold_ff;
        nxt_edge   = edge_ff;
        nxt_trial  = trial_ff;
        nxt_result = result_ff;
        nxt_count  = count_ff;
        case (state_ff)
            sarpr_pkg::ST_ACQ: begin
                if (trigger) begin
                    nxt_state = sarpr_pkg::ST_CONV;
                    nxt_hold  = 1'b1;
                    nxt_busy  = 1'b1;
                    nxt_edge  = 5'h00;
                    nxt_trial = sarpr_pkg::TRIAL_START;
                end
            end
            sarpr_pkg::ST_CONV: begin
                // Start pulses are not looked at here, so they cannot relaunch
                if (clk_rise) begin
                    nxt_edge = edge_inc;
                    if (edge_inc <= sarpr_pkg::CONV_EDGES) begin
                        // Keep the trial bit if the input lies above the trial level
                        nxt_trial[bit_idx] = cmp_above;
                        if (edge_inc < sarpr_pkg::CONV_EDGES) begin
                            nxt_trial[bit_idx - 4'h1] = 1'b1;
                        end
                    end else begin
                        // Offset binary to two's complement by inverting the sign bit
                        nxt_result = {~trial_ff[15], trial_ff[14:0]};
                        nxt_busy   = 1'b0;
                        nxt_hold   = 1'b0;
                        nxt_count  = count_ff + 16'h0001;
                        nxt_state  = sarpr_pkg::ST_ACQ;
                    end
                end
            end
            default: begin
                nxt_state = sarpr_pkg::ST_ACQ;
                nxt_busy  = 1'b0;
                nxt_hold  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff      <= sarpr_pkg::ST_ACQ;
            start_prev_ff <= 1'b1;
            clk_prev_ff   <= 1'b1;
            busy_ff       <= 1'b0;
            hold_ff       <= 1'b0;
            edge_ff       <= 5'h00;
            trial_ff      <= sarpr_pkg::TRIAL_START;
            result_ff     <= sarpr_pkg::RESULT_RST;
            count_ff      <= sarpr_pkg::COUNT_RST;
        end else begin
            state_ff      <= nxt_state;
            start_prev_ff <= conversion_start_n;
            clk_prev_ff   <= conv_clk;
            busy_ff       <= nxt_busy;
            hold_ff       <= nxt_hold;
            edge_ff       <= nxt_edge;
            trial_ff      <= nxt_trial;
            result_ff     <= nxt_result;
            count_ff      <= nxt_count;
        end
    end

    // Busy depends only on the sequencer; reads and sampling never touch it
    assign busy                       = busy_ff;
    assign sample_hold                = hold_ff;
    assign capacitive_weighting_array = trial_ff;

    sarpr_read_port u_read_port (
        .sys_clk         (sys_clk),
        .rst             (rst),
        .rdctl           (rdctl),
        .result          (result_ff),
        .result_bus_out  (result_bus_out),
        .result_bus_oe_n (result_bus_oe_n)
    );

    sarpr_avs_regs u_regs (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .req         (avs_req),
        .readdata    (avs_readdata),
        .waitrequest (avs_waitrequest),
        .start_en    (start_en),
        .sw_start    (sw_start),
        .busy        (busy_ff),
        .hold        (hold_ff),
        .edge_cnt    (edge_ff),
        .result      (result_ff),
        .conv_count  (count_ff)
    );

endmodule : sarpr_top

// File: testbench/sarpr_top_props.sv
// Pin-level checks of the conversion sequencer and result bus
`timescale 1ns/100ps
module sarpr_top_props (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    rst,
    // Watched pins
    input wire logic                    conv_clk,
    input wire logic                    conversion_start_n,
    input wire logic                    busy,
    input wire logic                    sample_hold,
    input wire sarpr_pkg::sarpr_rdctl_t rdctl,
    input wire logic [15:0]             result_bus_out,
    input wire logic [15:0]             result_bus_oe_n,
    input wire logic                    avs_write
);
    logic       prev_cc_ff;
    logic [4:0] rise_cnt_ff;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Rises counted only while busy is seen, so a start must not sit next to a rise
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_cc_ff  <= 1'b1;
            rise_cnt_ff <= 5'h00;
        end else begin
            prev_cc_ff  <= conv_clk;
            rise_cnt_ff <= busy ? rise_cnt_ff + {4'h0, conv_clk & ~prev_cc_ff} : 5'h00;
        end
    end
    oe_drive_a: assert property (
        result_bus_oe_n == {16{rdctl.cs_n | rdctl.rd_n}}) else $error("bus enable wrong");
    start_busy_a: assert property (
        $fell(conversion_start_n) && !rdctl.cs_n && !busy |-> ##[1:2] (busy && sample_hold))
        else $error("busy late");
    busy_keep_a: assert property (
        busy && !(conv_clk && !$past(conv_clk)) |=> busy) else $error("busy dropped early");
    conv_count_a: assert property (
        $fell(busy) |-> rise_cnt_ff == 5'h11) else $error("wrong edge count");
    busy_drop_a: assert property (
        rise_cnt_ff == 5'h11 |-> ##[0:2] (!busy && !sample_hold)) else $error("busy late low");
    quiet_busy_a: assert property (
        !busy && conversion_start_n && $past(conversion_start_n) && !avs_write |=> !busy)
        else $error("busy rose without start");
    upper_byte_a: assert property (
        rdctl.byte_sel |=> result_bus_out[15:8] == 8'h00) else $error("upper lines driven");
    byte_follow_a: assert property (
        !busy && !$past(busy) && !rdctl.byte_sel ##1 !busy && rdctl.byte_sel
        |=> result_bus_out[7:0] == $past(result_bus_out[15:8])) else $error("byte swap wrong");
endmodule : sarpr_top_props

// File: testbench/sarpr_host_model.sv
// Conversion clock source and comparator stand-in
`timescale 1ns/100ps
module sarpr_host_model (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Analog stand-in
    input wire logic [15:0] target,
    input wire logic [15:0] capacitive_weighting_array,
    output logic            cmp_above,
    output logic            conv_clk
);
    logic [2:0] ph_ff;
    // 50 ns phases: the fastest clock the converter accepts
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ph_ff    <= 3'h0;
            conv_clk <= 1'b0;
        end else begin
            ph_ff    <= (ph_ff == 3'h4) ? 3'h0 : ph_ff + 3'h1;
            conv_clk <= conv_clk ^ (ph_ff == 3'h4);
        end
    end
    // Target is two's complement, the trial code offset binary
    assign cmp_above = (target ^ 16'h8000) >= capacitive_weighting_array;
endmodule : sarpr_host_model

// File: testbench/sar_adc_parallel_read_interface_tb.sv
// Self-checking bench: conversions, result bus and register access
`timescale 1ns/100ps
module sar_adc_parallel_read_interface_tb;
    logic                    sys_clk;
    logic                    rst;
    logic                    conv_clk;
    logic                    start_n;
    logic                    busy;
    logic                    cmp;
    logic [15:0]             cwa;
    sarpr_pkg::sarpr_rdctl_t rdctl;
    logic [15:0]             bus;
    logic [15:0]             oe_n;
    logic [3:0]              adr;
    logic                    rd;
    logic                    wr;
    logic [31:0]             wdat;
    logic [31:0]             rdat;
    logic                    wait_r;
    logic [15:0]             target;
    logic [31:0]             got;
    int                      n_mismatch;
    int                      n_compared;
    int                      cyc;
    logic [15:0]             codes [4];
    sarpr_top u_dut (.sys_clk(sys_clk), .rst(rst), .conv_clk(conv_clk),
        .conversion_start_n(start_n), .busy(busy), .cmp_above(cmp),
        .capacitive_weighting_array(cwa), .sample_hold(), .rdctl(rdctl),
        .result_bus_out(bus), .result_bus_oe_n(oe_n), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_r));
    sarpr_host_model u_host (.sys_clk(sys_clk), .rst(rst), .target(target),
        .capacitive_weighting_array(cwa), .cmp_above(cmp), .conv_clk(conv_clk));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        adr  <= a;
        rd   <= ~w;
        wr   <= w;
        wdat <= d;
        do @(posedge sys_clk); while (wait_r !== 1'b0);
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : xfer
    // Byte select swapped while the read strobe stays low
    task automatic rd_pair(input logic [15:0] e);
        @(posedge sys_clk);
        rdctl <= '{cs_n: 1'b0, rd_n: 1'b0, byte_sel: 1'b0};
        repeat (5) @(posedge sys_clk);
        chk({oe_n, bus}, {16'h0, e});
        rdctl.byte_sel <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({oe_n, bus}, {24'h0, e[15:8]});
        rdctl <= '{cs_n: 1'b0, rd_n: 1'b1, byte_sel: 1'b0};
        // Long strobe-high gap also keeps reads clear of the next start fall
        repeat (13) @(posedge sys_clk);
    endtask : rd_pair
    task automatic pulse();
        start_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        start_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : pulse
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        {rst, start_n, rd, wr, adr, wdat, target, n_mismatch, n_compared, cyc} = '0;
        rst = 1'b1;
        start_n = 1'b1;
        rdctl = '{cs_n: 1'b0, rd_n: 1'b1, byte_sel: 1'b0};
        codes = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        chk({31'h0, busy}, 32'h0);
        xfer(1'b0, sarpr_pkg::OFF_CTRL, 32'h0);
        chk(got, 32'h1);
        xfer(1'b0, 4'h2, 32'h0);
        chk(got, 32'h0);
        foreach (codes[i]) begin
            target <= codes[i];
            while (conv_clk !== 1'b0) @(posedge sys_clk);
            while (conv_clk !== 1'b1) @(posedge sys_clk);
            pulse();
            chk({31'h0, busy}, 32'h1);
            pulse();
            while (busy !== 1'b0) @(posedge sys_clk);
            repeat (40) @(posedge sys_clk);
            chk({31'h0, busy}, 32'h0);
            rd_pair(codes[i]);
            xfer(1'b0, sarpr_pkg::OFF_RESULT, 32'h0);
            chk(got, {16'h0, codes[i]});
        end
        rdctl <= '{cs_n: 1'b1, rd_n: 1'b0, byte_sel: 1'b0};
        pulse();
        chk({busy, oe_n}, 32'hffff);
        rd_pair(codes[3]);
        xfer(1'b0, sarpr_pkg::OFF_COUNT, 32'h0);
        chk(got, 32'h4);
        xfer(1'b1, sarpr_pkg::OFF_CTRL, 32'h0);
        xfer(1'b0, sarpr_pkg::OFF_CTRL, 32'h0);
        chk(got, 32'h0);
        // Software start with the enable cleared must be refused
        xfer(1'b1, sarpr_pkg::OFF_CTRL, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, busy}, 32'h0);
        rdctl <= '{cs_n: 1'b1, rd_n: 1'b1, byte_sel: 1'b0};
        xfer(1'b1, sarpr_pkg::OFF_CTRL, 32'h3);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, busy}, 32'h1);
        xfer(1'b0, sarpr_pkg::OFF_STATUS, 32'h0);
        chk({30'h0, got[1:0]}, 32'h3);
        while (busy !== 1'b0) @(posedge sys_clk);
        repeat (40) @(posedge sys_clk);
        xfer(1'b0, sarpr_pkg::OFF_STATUS, 32'h0);
        chk(got, {19'h0, sarpr_pkg::LATCH_EDGE, 8'h00});
        rd_pair(codes[3]);
        xfer(1'b0, sarpr_pkg::OFF_COUNT, 32'h0);
        chk(got, 32'h5);
        print_verdict();
    end
endmodule : sar_adc_parallel_read_interface_tb
bind sarpr_top sarpr_top_props u_props (.sys_clk(sys_clk), .rst(rst), .conv_clk(conv_clk),
    .conversion_start_n(conversion_start_n), .busy(busy), .sample_hold(sample_hold),
    .rdctl(rdctl), .result_bus_out(result_bus_out), .result_bus_oe_n(result_bus_oe_n),
    .avs_write(avs_write));
